// File: rtl/bip_pkg.sv
// Purpose: Shared constants and carriers for the bidirectional I/O port block
// Assumes: Byte registers sit in the low lane of 32-bit Wishbone words
// Notes:   Port index 0 is L, 1 is G, 2 is C
package bip_pkg;

  localparam int          PORT_W       = 8;
  localparam int          NUM_PORTS    = 3;
  localparam int          PORT_L       = 0;
  localparam int          PORT_G       = 1;
  localparam int          PORT_C       = 2;

  // Register byte offsets
  localparam logic [7:0]  OFS_L_CFG    = 8'h00;
  localparam logic [7:0]  OFS_L_DATA   = 8'h04;
  localparam logic [7:0]  OFS_L_PIN    = 8'h08;
  localparam logic [7:0]  OFS_G_CFG    = 8'h0c;
  localparam logic [7:0]  OFS_G_DATA   = 8'h10;
  localparam logic [7:0]  OFS_G_PIN    = 8'h14;
  localparam logic [7:0]  OFS_C_CFG    = 8'h18;
  localparam logic [7:0]  OFS_C_DATA   = 8'h1c;
  localparam logic [7:0]  OFS_C_PIN    = 8'h20;

  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [7:0]  G_DATA_RD_MASK = 8'h3f;

  // G port bit positions
  localparam int          G_EXTERNAL_INTERRUPT_IN_BIT   = 0;
  localparam int          G_WDOG_BIT   = 1;
  localparam int          G_T1CAP_BIT  = 2;
  localparam int          G_T1IO_BIT   = 3;
  localparam int          G_SO_BIT     = 4;
  localparam int          G_SK_BIT     = 5;
  localparam int          G_SI_BIT     = 6;
  localparam int          G_CKO_BIT    = 7;
  localparam int          G_IDLE_BIT   = 6;
  localparam int          G_HALT_BIT   = 7;
  localparam int          G_ALTSK_BIT  = 6;
  localparam int          G_DLY_BIT    = 7;

  // L port timer pins
  localparam int          L_T2A_BIT    = 4;
  localparam int          L_T2B_BIT    = 5;
  localparam int          L_T3A_BIT    = 6;
  localparam int          L_T3B_BIT    = 7;

  localparam int          STARTUP_CYCLES = 256;

  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_HALT, PWR_START} bip_pwr_t;

  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] pull_up;
  } bip_pad_t;

  typedef struct packed {
    logic [PORT_W-1:0] multi_pin_wakeup;
    logic              timer2_pin_a;
    logic              timer2_pin_b;
    logic              timer3_pin_a;
    logic              timer3_pin_b;
    logic              external_interrupt_in;
    logic              timer1_capture_pin;
    logic              timer1_io_pin;
    logic              serial_data_out;
    logic              serial_clock;
    logic              serial_data_in;
  } bip_alt_t;

endpackage : bip_pkg

// File: rtl/bip_port_set.sv
// Purpose: Three memory-mapped 8-bit bidirectional ports with G port specials
// Assumes: Pad inputs arrive on clk; Wishbone classic slave, one wait state
// Notes:   Pad drive follows the registers one clock later
`timescale 1ns/100ps
`default_nettype none

module bip_port_set #(
  parameter int DLY_CYCLES = bip_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Pads
  input  wire logic [7:0]        l_pad_in,
  input  wire logic [7:0]        g_pad_in,
  input  wire logic [7:0]        c_pad_in,
  output bip_pkg::bip_pad_t      l_pad,
  output bip_pkg::bip_pad_t      g_pad,
  output bip_pkg::bip_pad_t      c_pad,
  // Chip-level inputs
  input  wire logic              rc_osc_option,
  input  wire logic              osc_clk_level,
  input  wire logic              wd_error_level,
  input  wire logic              wake_in,
  // Peripheral and power outputs
  output bip_pkg::bip_alt_t      alt_in,
  output logic                   halt_mode,
  output logic                   idle_mode,
  output logic                   startup_delay_busy,
  output logic                   serial_clock_alt_phase
);

  localparam int CW = $clog2(DLY_CYCLES + 1);

  if (DLY_CYCLES < 1 || DLY_CYCLES > 4096)
  begin : g_bad_dly
    $error("DLY_CYCLES out of range");
  end

  logic [7:0]            cfg_ff [bip_pkg::NUM_PORTS];
  logic [7:0]            data_ff [bip_pkg::NUM_PORTS];
  logic [7:0]            meta_ff [bip_pkg::NUM_PORTS];
  logic [7:0]            sync_ff [bip_pkg::NUM_PORTS];
  logic                  g7_prev_ff;
  logic                  ack_ff;
  logic [31:0]           rdat_ff;
  bip_pkg::bip_pwr_t     pwr_ff;
  bip_pkg::bip_pwr_t     nxt_pwr;
  logic [CW-1:0]         dly_ff;
  bip_pkg::bip_pad_t     l_pad_ff;
  bip_pkg::bip_pad_t     g_pad_ff;
  bip_pkg::bip_pad_t     c_pad_ff;
  bip_pkg::bip_pad_t     nxt_g_pad;
  bip_pkg::bip_alt_t     alt_ff;
  logic                  halt_ff;
  logic                  idle_ff;
  logic                  busy_ff;
  logic                  altsk_ff;

  logic                  req;
  logic                  wr;
  logic                  g7_rise;
  logic                  wake_halt;
  logic [7:0]            rd_byte;

  function automatic bip_pkg::bip_pad_t decode_pad(input logic [7:0] cfg,
                                                  input logic [7:0] data);
    bip_pkg::bip_pad_t p;
    p.oe      = cfg;
    p.out     = cfg & data;
    p.pull_up = ~cfg & data;
    return p;
  endfunction : decode_pad

  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // Bus answer: one wait state, ack held for a single cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req;
  end

  always_comb
  begin
    unique case (wb_adr_i)
      bip_pkg::OFS_L_CFG:  rd_byte = cfg_ff[bip_pkg::PORT_L];
      bip_pkg::OFS_L_DATA: rd_byte = data_ff[bip_pkg::PORT_L];
      bip_pkg::OFS_L_PIN:  rd_byte = sync_ff[bip_pkg::PORT_L];
      bip_pkg::OFS_G_CFG:  rd_byte = cfg_ff[bip_pkg::PORT_G];
      bip_pkg::OFS_G_DATA: rd_byte = data_ff[bip_pkg::PORT_G]
                                     & bip_pkg::G_DATA_RD_MASK;
      bip_pkg::OFS_G_PIN:  rd_byte = sync_ff[bip_pkg::PORT_G];
      bip_pkg::OFS_C_CFG:  rd_byte = cfg_ff[bip_pkg::PORT_C];
      bip_pkg::OFS_C_DATA: rd_byte = data_ff[bip_pkg::PORT_C];
      bip_pkg::OFS_C_PIN:  rd_byte = sync_ff[bip_pkg::PORT_C];
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdat_ff <= 32'h0000_0000;
    else if (req && !wb_we_i)
      rdat_ff <= {24'h00_0000, rd_byte};
  end

  // Config and latch registers; software may flip any single bit
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int p = 0; p < bip_pkg::NUM_PORTS; p++)
      begin
        cfg_ff[p]  <= bip_pkg::CFG_RST;
        data_ff[p] <= bip_pkg::DATA_RST;
      end
    end
    else if (wr)
    begin
      for (int p = 0; p < bip_pkg::NUM_PORTS; p++)
      begin
        if (wb_adr_i == bip_pkg::OFS_L_CFG + 8'(p * 12))
          cfg_ff[p] <= wb_dat_i[7:0];
        if (wb_adr_i == bip_pkg::OFS_L_DATA + 8'(p * 12))
          data_ff[p] <= wb_dat_i[7:0];
      end
    end
  end

  // Two-stage pin synchronisers; only the second stage is used
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int p = 0; p < bip_pkg::NUM_PORTS; p++)
      begin
        meta_ff[p] <= 8'h00;
        sync_ff[p] <= 8'h00;
      end
      g7_prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff[bip_pkg::PORT_L] <= l_pad_in;
      meta_ff[bip_pkg::PORT_G] <= g_pad_in;
      meta_ff[bip_pkg::PORT_C] <= c_pad_in;
      for (int p = 0; p < bip_pkg::NUM_PORTS; p++)
        sync_ff[p] <= meta_ff[p];
      g7_prev_ff <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_CKO_BIT];
    end
  end

  assign g7_rise   = sync_ff[bip_pkg::PORT_G][bip_pkg::G_CKO_BIT] && !g7_prev_ff;
  assign wake_halt = wake_in || (rc_osc_option && g7_rise);

  // Power mode: in run or idle, a halt or idle write beats a wake in the same cycle
  always_comb
  begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      bip_pkg::PWR_RUN, bip_pkg::PWR_IDLE:
      begin
        if (pwr_ff == bip_pkg::PWR_IDLE && wake_in)
          nxt_pwr = bip_pkg::PWR_RUN;
        if (wr && wb_adr_i == bip_pkg::OFS_G_DATA && wb_dat_i[bip_pkg::G_IDLE_BIT])
          nxt_pwr = bip_pkg::PWR_IDLE;
        if (wr && wb_adr_i == bip_pkg::OFS_G_DATA && wb_dat_i[bip_pkg::G_HALT_BIT])
          nxt_pwr = bip_pkg::PWR_HALT;
      end
      bip_pkg::PWR_HALT:
      begin
        if (wake_halt)
          nxt_pwr = (rc_osc_option && cfg_ff[bip_pkg::PORT_G][bip_pkg::G_DLY_BIT])
                    ? bip_pkg::PWR_START : bip_pkg::PWR_RUN;
      end
      bip_pkg::PWR_START:
      begin
        if (dly_ff == CW'(1))
          nxt_pwr = bip_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pwr_ff <= bip_pkg::PWR_RUN;
    else
      pwr_ff <= nxt_pwr;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      dly_ff <= '0;
    else if (pwr_ff == bip_pkg::PWR_HALT && nxt_pwr == bip_pkg::PWR_START)
      dly_ff <= CW'(DLY_CYCLES);
    else if (dly_ff != '0)
      dly_ff <= dly_ff - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      halt_ff  <= 1'b0;
      idle_ff  <= 1'b0;
      busy_ff  <= 1'b0;
      altsk_ff <= 1'b0;
    end
    else
    begin
      halt_ff  <= nxt_pwr == bip_pkg::PWR_HALT;
      idle_ff  <= nxt_pwr == bip_pkg::PWR_IDLE;
      busy_ff  <= nxt_pwr == bip_pkg::PWR_START;
      altsk_ff <= cfg_ff[bip_pkg::PORT_G][bip_pkg::G_ALTSK_BIT];
    end
  end

  // G port pad drive with its dedicated pins overridden
  always_comb
  begin
    nxt_g_pad = decode_pad(cfg_ff[bip_pkg::PORT_G], data_ff[bip_pkg::PORT_G]);
    nxt_g_pad.out[bip_pkg::G_WDOG_BIT]     = wd_error_level;
    nxt_g_pad.oe[bip_pkg::G_WDOG_BIT]      = 1'b1;
    nxt_g_pad.pull_up[bip_pkg::G_WDOG_BIT] = 1'b0;
    nxt_g_pad.out[bip_pkg::G_SI_BIT]       = 1'b0;
    nxt_g_pad.oe[bip_pkg::G_SI_BIT]        = 1'b0;
    nxt_g_pad.pull_up[bip_pkg::G_SI_BIT]   = 1'b0;
    nxt_g_pad.out[bip_pkg::G_CKO_BIT]      = !rc_osc_option && osc_clk_level;
    nxt_g_pad.oe[bip_pkg::G_CKO_BIT]       = !rc_osc_option;
    nxt_g_pad.pull_up[bip_pkg::G_CKO_BIT]  = 1'b0;
  end

  // Pads sit hi-z during reset, only the watchdog pin keeps driving
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      l_pad_ff <= '0;
      c_pad_ff <= '0;
      g_pad_ff <= '0;
      g_pad_ff.oe[bip_pkg::G_WDOG_BIT] <= 1'b1;
    end
    else
    begin
      l_pad_ff <= decode_pad(cfg_ff[bip_pkg::PORT_L], data_ff[bip_pkg::PORT_L]);
      c_pad_ff <= decode_pad(cfg_ff[bip_pkg::PORT_C], data_ff[bip_pkg::PORT_C]);
      g_pad_ff <= nxt_g_pad;
    end
  end

  // Alternate-function views of the synchronised pins
  always_ff @(posedge clk)
  begin
    if (srst)
      alt_ff <= '0;
    else
    begin
      alt_ff.multi_pin_wakeup      <= sync_ff[bip_pkg::PORT_L];
      alt_ff.timer2_pin_a          <= sync_ff[bip_pkg::PORT_L][bip_pkg::L_T2A_BIT];
      alt_ff.timer2_pin_b          <= sync_ff[bip_pkg::PORT_L][bip_pkg::L_T2B_BIT];
      alt_ff.timer3_pin_a          <= sync_ff[bip_pkg::PORT_L][bip_pkg::L_T3A_BIT];
      alt_ff.timer3_pin_b          <= sync_ff[bip_pkg::PORT_L][bip_pkg::L_T3B_BIT];
      alt_ff.external_interrupt_in <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_EXTERNAL_INTERRUPT_IN_BIT];
      alt_ff.timer1_capture_pin    <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_T1CAP_BIT];
      alt_ff.timer1_io_pin         <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_T1IO_BIT];
      alt_ff.serial_data_out       <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_SO_BIT];
      alt_ff.serial_clock          <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_SK_BIT];
      alt_ff.serial_data_in        <= sync_ff[bip_pkg::PORT_G][bip_pkg::G_SI_BIT];
    end
  end

  assign wb_ack_o               = ack_ff;
  assign wb_dat_o               = rdat_ff;
  assign l_pad                  = l_pad_ff;
  assign g_pad                  = g_pad_ff;
  assign c_pad                  = c_pad_ff;
  assign alt_in                 = alt_ff;
  assign halt_mode              = halt_ff;
  assign idle_mode              = idle_ff;
  assign startup_delay_busy     = busy_ff;
  assign serial_clock_alt_phase = altsk_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic halt_wr;
  assign halt_wr = wr && wb_adr_i == bip_pkg::OFS_G_DATA
                   && wb_dat_i[bip_pkg::G_HALT_BIT] && pwr_ff != bip_pkg::PWR_HALT
                   && pwr_ff != bip_pkg::PWR_START;

  // Delay spans can exceed what a plain delay may count, so count them here
  logic [CW-1:0]         busy_len_ff;
  always_ff @(posedge clk)
    busy_len_ff <= (srst || !startup_delay_busy) ? '0 : busy_len_ff + CW'(1);

  chk_pad_decode_c: assert property (
    c_pad.oe == $past(cfg_ff[bip_pkg::PORT_C])
    && c_pad.pull_up == ($past(~cfg_ff[bip_pkg::PORT_C] & data_ff[bip_pkg::PORT_C])))
    else $error("C pad drive does not match config and latch");
  chk_l_drive_level: assert property (
    l_pad.out == ($past(cfg_ff[bip_pkg::PORT_L]) & $past(data_ff[bip_pkg::PORT_L])))
    else $error("L pad level does not match latch");
  chk_halt_entry: assert property (
    halt_wr |=> halt_mode && !idle_mode)
    else $error("Halt write did not enter halt");
  chk_idle_entry: assert property (
    wr && wb_adr_i == bip_pkg::OFS_G_DATA && wb_dat_i[7:6] == 2'b01
    && pwr_ff == bip_pkg::PWR_RUN |=> idle_mode && !halt_mode)
    else $error("Idle write did not enter idle");
  chk_alt_phase: assert property (
    serial_clock_alt_phase == $past(cfg_ff[bip_pkg::PORT_G][bip_pkg::G_ALTSK_BIT]))
    else $error("Serial clock phase select wrong");
  chk_delay_len: assert property (
    $fell(startup_delay_busy) |-> busy_len_ff == CW'(DLY_CYCLES))
    else $error("Start-up delay length wrong");
  chk_g_read_mask: assert property (
    req && !wb_we_i && wb_adr_i == bip_pkg::OFS_G_DATA |=> wb_ack_o && wb_dat_o[7:6] == 2'b00)
    else $error("G latch bits 6 and 7 read non-zero");
  chk_g7_wake: assert property (
    pwr_ff == bip_pkg::PWR_HALT && rc_osc_option && g7_rise |=> !halt_mode)
    else $error("G7 rising edge did not end halt");
  chk_crystal_g7: assert property (
    !$past(srst) && !$past(rc_osc_option)
    |-> g_pad.oe[bip_pkg::G_CKO_BIT] && !g_pad.pull_up[bip_pkg::G_CKO_BIT])
    else $error("G7 not an oscillator output in crystal mode");
  chk_watchdog_pin: assert property (
    g_pad.oe[bip_pkg::G_WDOG_BIT]
    && ($past(srst) || g_pad.out[bip_pkg::G_WDOG_BIT] == $past(wd_error_level)))
    else $error("Watchdog pin not driven from error level");
  chk_pin_sync: assert property (
    ##3 alt_in.multi_pin_wakeup == $past(l_pad_in, 3))
    else $error("L pins not seen after synchronisation");

  cov_halt_rc_delay: cover property (halt_mode ##[1:50] startup_delay_busy);
  cov_idle_wake: cover property (idle_mode ##1 !idle_mode);
  cov_pull_up: cover property (|l_pad.pull_up);

endmodule : bip_port_set

`default_nettype wire

// File: dv/bip_pin_model.sv
// Purpose: Pin-side model of one 8-bit port: external drivers, pull-ups, floating pins
// Assumes: External drivers may be enabled on any pin; where the device also drives, the device level wins
// Notes:   A floating pin toggles every clock, so a missing pull-up never reads stable
`timescale 1ns/100ps
`default_nettype none

module bip_pin_model (
  // Clock
  input  wire logic              clk,
  // Device side
  input  wire bip_pkg::bip_pad_t pad,
  // External drivers
  input  wire logic [7:0]        ext_en,
  input  wire logic [7:0]        ext_val,
  // Resolved pin levels
  output logic      [7:0]        level
);

  logic [7:0] float_ff = 8'h5a;

  always_ff @(posedge clk)
  begin
    float_ff <= ~float_ff;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad.oe[i])
        level[i] = pad.out[i];
      else if (ext_en[i])
        level[i] = ext_val[i];
      else if (pad.pull_up[i])
        level[i] = 1'b1;
      else
        level[i] = float_ff[i];
    end
  end

endmodule : bip_pin_model
`default_nettype wire

// File: dv/test_bidir_io_port_set.sv
// Purpose: Self-checking bench for the bidirectional port block
// Assumes: Wishbone answer one cycle after take; start-up delay shortened to 4
// Notes:   Hi-z pins float in the pin model, so only driven or pulled pins are read
`timescale 1ns/100ps
`default_nettype none

module test_bidir_io_port_set;

  localparam int     DLY = 4;
  logic              clk = 1'b0;
  logic              srst;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [7:0]        wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic [7:0]        pin [3];
  logic [7:0]        ext_en [3];
  logic [7:0]        ext_val [3];
  bip_pkg::bip_pad_t pads [3];
  bip_pkg::bip_alt_t alt_in;
  logic              rc_osc_option;
  logic              osc_clk_level;
  logic              wd_error_level;
  logic              wake_in;
  logic              halt_mode;
  logic              idle_mode;
  logic              startup_delay_busy;
  logic              serial_clock_alt_phase;
  int                miscompares = 0;
  int                check_count = 0;

  bip_port_set #(.DLY_CYCLES(DLY)) bip_port_set_inst (
    .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .l_pad_in(pin[0]), .g_pad_in(pin[1]),
    .c_pad_in(pin[2]), .l_pad(pads[0]), .g_pad(pads[1]), .c_pad(pads[2]),
    .rc_osc_option(rc_osc_option), .osc_clk_level(osc_clk_level),
    .wd_error_level(wd_error_level), .wake_in(wake_in), .alt_in(alt_in),
    .halt_mode(halt_mode), .idle_mode(idle_mode), .startup_delay_busy(startup_delay_busy),
    .serial_clock_alt_phase(serial_clock_alt_phase)
  );

  for (genvar p = 0; p < 3; p++)
  begin : g_pins
    bip_pin_model bip_pin_model_inst (.clk(clk), .pad(pads[p]), .ext_en(ext_en[p]),
                                      .ext_val(ext_val[p]), .level(pin[p]));
  end

  always #4 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One classic cycle; the request stays put until ack is sampled high
  task automatic bus(input logic [7:0] a, input logic we, input logic [3:0] sel,
                     input logic [7:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, 4'h1, d, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 4'h1, 8'h00, q);
    check(what, q, {24'h000000, exp});
  endtask : rdchk

  task automatic t_reset();
    logic [31:0] q;
    srst <= 1'b1;
    // Pull every pin low from outside so the pin reads are defined
    ext_en         <= '{default: 8'hff};
    ext_val        <= '{default: 8'h00};
    wd_error_level <= 1'b0;
    tick(10);
    srst <= 1'b0;
    tick(1);
    for (int a = 0; a <= 32; a += 4)
      rdchk("reg after reset", 8'(a), 8'h00);
    check("l c oe", {pads[0].oe, pads[2].oe}, 16'h0000);
    check("g oe", pads[1].oe, {~rc_osc_option, 7'h02});
    check("pull ups", {pads[0].pull_up, pads[1].pull_up, pads[2].pull_up}, 24'h0);
    check("modes", {halt_mode, idle_mode, startup_delay_busy}, 3'b000);
    bus(8'h24, 1'b1, 4'h1, 8'hff, q);
    rdchk("unmapped", 8'h24, 8'h00);
    bus(bip_pkg::OFS_L_CFG, 1'b1, 4'h0, 8'hff, q);
    rdchk("sel0 write", bip_pkg::OFS_L_CFG, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // The four bits of each nibble take the four different set-ups
  task automatic t_lc_ports();
    logic [7:0] base;
    for (int p = 0; p < 3; p += 2)
    begin
      base = 8'(p * 12);
      ext_en[p]  <= 8'h11;
      ext_val[p] <= 8'h01;
      wr(base, 8'hcc);
      wr(base + 8'h04, 8'haa);
      check("oe", pads[p].oe, 8'hcc);
      check("out", pads[p].out & 8'hcc, 8'h88);
      check("pull up", pads[p].pull_up, 8'h22);
      tick(4);
      rdchk("pins", base + 8'h08, 8'hab);
      rdchk("cfg", base, 8'hcc);
      rdchk("latch", base + 8'h04, 8'haa);
    end
    check("wakeup", alt_in.multi_pin_wakeup, 8'hab);
    check("timers", {alt_in.timer2_pin_a, alt_in.timer2_pin_b,
                     alt_in.timer3_pin_a, alt_in.timer3_pin_b}, 4'h5);
    $display("test l and c ports done");
  endtask : t_lc_ports

  task automatic t_g_port();
    ext_en[1]  <= 8'h41;
    ext_val[1] <= 8'h41;
    wr(bip_pkg::OFS_G_CFG, 8'h38);
    wr(bip_pkg::OFS_G_DATA, 8'h14);
    check("g oe", pads[1].oe, 8'hba);
    check("g out", pads[1].out & 8'hba, 8'h10);
    check("g pull up", pads[1].pull_up, 8'h04);
    tick(4);
    rdchk("g pins", bip_pkg::OFS_G_PIN, 8'h55);
    check("g alt", {alt_in.external_interrupt_in, alt_in.timer1_capture_pin,
                    alt_in.timer1_io_pin, alt_in.serial_data_out, alt_in.serial_clock,
                    alt_in.serial_data_in}, 6'b110101);
    osc_clk_level  <= 1'b1;
    wd_error_level <= 1'b1;
    tick(3);
    check("osc out", pads[1].out[7], 1'b1);
    check("wd out", pads[1].out[1], 1'b1);
    rc_osc_option <= 1'b1;
    tick(3);
    check("g7 oe rc", pads[1].oe[7], 1'b0);
    $display("test g port done");
  endtask : t_g_port

  task automatic wake();
    wake_in <= 1'b1;
    tick(1);
    wake_in <= 1'b0;
    tick(3);
  endtask : wake

  task automatic t_power();
    int n;
    // A floating G7 in RC mode would end halt at once, so hold it low
    ext_en[1]  <= 8'h80;
    ext_val[1] <= 8'h00;
    wr(bip_pkg::OFS_G_DATA, 8'h80);
    check("halt", halt_mode, 1'b1);
    rdchk("g latch halt", bip_pkg::OFS_G_DATA, 8'h00);
    wake();
    check("halt end", halt_mode, 1'b0);
    wr(bip_pkg::OFS_G_DATA, 8'h40);
    check("idle", idle_mode, 1'b1);
    rdchk("g latch idle", bip_pkg::OFS_G_DATA, 8'h00);
    wake();
    check("idle end", idle_mode, 1'b0);
    wr(bip_pkg::OFS_G_CFG, 8'hc0);
    check("alt phase", serial_clock_alt_phase, 1'b1);
    ext_en[1]  <= 8'h80;
    ext_val[1] <= 8'h00;
    wr(bip_pkg::OFS_G_DATA, 8'h80);
    check("halt rc", halt_mode, 1'b1);
    ext_val[1] <= 8'h80;
    n = 0;
    while (startup_delay_busy !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    n = 0;
    while (startup_delay_busy === 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check("delay length", n, DLY);
    check("run after delay", {halt_mode, idle_mode}, 2'b00);
    $display("test power done");
  endtask : t_power

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial
  begin
    srst           = 1'b1;
    wb_cyc_i       = 1'b0;
    wb_stb_i       = 1'b0;
    wb_we_i        = 1'b0;
    wb_adr_i       = 8'h00;
    wb_sel_i       = 4'h0;
    wb_dat_i       = 32'h00000000;
    ext_en         = '{default: 8'h00};
    ext_val        = '{default: 8'h00};
    rc_osc_option  = 1'b0;
    osc_clk_level  = 1'b0;
    wd_error_level = 1'b0;
    wake_in        = 1'b0;
    t_reset();
    t_lc_ports();
    t_g_port();
    t_power();
    t_reset();
    give_verdict();
  end

  // The whole run needs well under a thousand cycles
  initial
  begin
    tick(5000);
    miscompares++;
    give_verdict();
  end

endmodule : test_bidir_io_port_set
`default_nettype wire
